/* hdl/csio_pkg.sv */
// shared constants for the clocked serial port pin control
package csio_pkg;
    localparam int unsigned DATA_W = 8;
    localparam logic [3:0] BIT_COUNT_END = 4'h8;
    localparam logic [3:0] BIT_COUNT_ZERO = 4'h0;
    localparam logic [7:0] SHIFT_RESET = 8'h00;
    localparam int unsigned CLK_MHZ = 200;
    localparam int unsigned DIV_DEFAULT = 8;
    localparam int unsigned DIV_W = 8;
    localparam logic [DIV_W-1:0] DIV_ZERO = 8'h00;
endpackage

/* hdl/clocked_serial_port_pin_control.sv */
// pin and shift control of a clocked serial port
//
// How it works
// R1: both clock select bits zero selects slave, else master with internal clock
// R2: transfer start flag zero is wait, one is released
// R3: slave: clock pin is general input or external clock input; direction one output
// R4: master: direction zero general input; direction one holds high waiting, clocks released
// R5: select zero: shared pin general input or serial input, direction one general output
// R6: three-wire, drive enable one: MSB out on dedicated pin on falling edges
// R7: LSB takes input pin level on rising edge, or output latch if pin outputs
// R8: clock counter counts falling edges of the clock pin in every mode
// R9: two-wire select one: shared pin gives serial output regardless of direction
// R10: two-wire drive enable zero: dedicated pin general port, else serial output
// R11: two-wire direction select one: MSB out on shared pin on falling edges
// R12: pin reset: all three pins general input, shift register undefined; the code clears it to 8'h00 (SHIFT_RESET)
// R13: watchdog or stack reset: pins general input, shift register retained
// R14: clock stop: pins hold state, shift register retained
// R15: halt freezes internal clock output; external clock keeps shifting
// R16: counter at eight, next rising edge clears it and returns to wait
// R17: writing zero to start flag forces wait and clears counter
// R18: interrupt pulse once eight shift clocks are done
// R19: shift register eight bits, loaded and read through the data buffer
`timescale 1ns/1ps
module clocked_serial_port_pin_control
    import csio_pkg::*;
#(
    parameter int unsigned HALF_DIV = DIV_DEFAULT
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic watchdogStackReset,
    input wire logic clockStop,
    input wire logic halt,
    input wire logic clockSelectHigh,
    input wire logic clockSelectLow,
    input wire logic twoWireMode,
    input wire logic transferStartWrite,
    input wire logic transferStartValue,
    input wire logic dataIoSelect,
    input wire logic outputDriveEnable,
    input wire logic transferDirectionSelect,
    input wire logic clockPinDirection,
    input wire logic sharedPinDirection,
    input wire logic outputPinDirection,
    input wire logic [2:0] portLatch,
    input wire logic shiftLoad,
    input wire logic [7:0] shiftLoadData,
    input wire logic portBitZeroIn,
    input wire logic portBitOneIn,
    input wire logic portBitTwoIn,
    output logic portBitZeroOut,
    output logic portBitZeroOe,
    output logic portBitOneOut,
    output logic portBitOneOe,
    output logic portBitTwoOut,
    output logic portBitTwoOe,
    output logic transferStartFlag,
    output logic [7:0] serialShiftReg,
    output logic [2:0] pinSample,
    output logic shiftDoneIrq
);
    // ---------------------------------------------------------------
    // state
    // ---------------------------------------------------------------
    typedef struct packed {
        logic [2:0] sync1;
        logic [2:0] sync2;
        logic sckPrev;
        logic released;
        logic [3:0] count;
        logic [7:0] shift;
        logic serOut;
        logic intSck;
        logic [DIV_W-1:0] div;
        logic p0o, p0e, p1o, p1e, p2o, p2e;
        logic irq;
    } state_t;

    state_t s_q, s_d;
    logic master, sckNow, fallEdge, riseEdge, sdiIn;

    function automatic logic pinOrLatch(input logic isOut, input logic latch, input logic pin);
        pinOrLatch = isOut ? latch : pin;
    endfunction

    always_comb begin
        s_d = s_q;
        s_d.irq = 1'b0;
        s_d.sync1 = {portBitTwoIn, portBitOneIn, portBitZeroIn};
        s_d.sync2 = s_q.sync1;
        master = clockSelectHigh | clockSelectLow; // see R1
        // clock counter reads the pin itself, not the source of the clock
        sckNow = clockPinDirection ? s_q.p0o : s_q.sync2[0]; // see R8
        fallEdge = s_q.sckPrev & ~sckNow;
        riseEdge = ~s_q.sckPrev & sckNow;
        s_d.sckPrev = sckNow;
        // two-wire receive uses the shared pin, same as three-wire
        sdiIn = pinOrLatch(sharedPinDirection, portLatch[1], s_q.sync2[1]); // see R7
        if (clockStop) begin
            s_d = s_q; // see R14
            s_d.irq = 1'b0;
            s_d.count = BIT_COUNT_ZERO;
        end else begin
            // internal clock generator, frozen in halt
            if (master && s_q.released && !halt) begin // see R15
                if (s_q.div == DIV_W'(HALF_DIV - 1)) begin
                    s_d.div = DIV_ZERO;
                    s_d.intSck = ~s_q.intSck;
                end else begin
                    s_d.div = s_q.div + 1'b1;
                end
            end else if (!s_q.released) begin
                s_d.intSck = 1'b1; // see R4
                s_d.div = DIV_ZERO;
            end
            if (s_q.released && fallEdge && s_q.count != BIT_COUNT_END) begin
                s_d.count = s_q.count + 1'b1; // see R8
                s_d.serOut = s_q.shift[DATA_W-1]; // see R6 R11
                s_d.shift = {s_q.shift[DATA_W-2:0], 1'b0};
            end
            if (s_q.released && riseEdge) begin
                // the eighth rise still carries a bit, so take it before closing
                if (!twoWireMode || !transferDirectionSelect) begin
                    s_d.shift[0] = sdiIn; // see R7
                end
                if (s_q.count == BIT_COUNT_END) begin
                    s_d.count = BIT_COUNT_ZERO; // see R16
                    s_d.released = 1'b0;
                    s_d.irq = 1'b1; // see R18
                    s_d.intSck = 1'b1;
                end
            end
            if (shiftLoad) begin
                s_d.shift = shiftLoadData; // see R19
                s_d.serOut = shiftLoadData[DATA_W-1];
            end
            if (transferStartWrite) begin
                if (!transferStartValue) begin
                    s_d.released = 1'b0; // see R17
                    s_d.count = BIT_COUNT_ZERO;
                end else begin
                    s_d.released = 1'b1; // see R2
                end
            end
            // clock pin
            s_d.p0e = clockPinDirection; // see R3 R4
            s_d.p0o = (master && clockPinDirection) ? s_d.intSck : portLatch[0];
            // shared pin
            if (twoWireMode && dataIoSelect) begin
                s_d.p1e = 1'b1; // see R9
                s_d.p1o = s_d.serOut;
            end else begin
                s_d.p1e = sharedPinDirection; // see R5
                s_d.p1o = portLatch[1];
            end
            // dedicated output pin
            if (outputDriveEnable) begin
                s_d.p2e = 1'b1; // see R6 R10
                s_d.p2o = s_d.serOut;
            end else begin
                s_d.p2e = outputPinDirection; // see R10
                s_d.p2o = portLatch[2];
            end
        end
        if (watchdogStackReset) begin
            s_d.p0e = 1'b0; // see R13
            s_d.p1e = 1'b0;
            s_d.p2e = 1'b0;
            s_d.released = 1'b0;
            s_d.count = BIT_COUNT_ZERO;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            s_q <= '0; // see R12
            s_q.shift <= SHIFT_RESET;
            s_q.intSck <= 1'b1;
            // clock pin idles high: a low here would fake a rise after reset
            s_q.sckPrev <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    assign portBitZeroOut = s_q.p0o;
    assign portBitZeroOe = s_q.p0e;
    assign portBitOneOut = s_q.p1o;
    assign portBitOneOe = s_q.p1e;
    assign portBitTwoOut = s_q.p2o;
    assign portBitTwoOe = s_q.p2e;
    assign transferStartFlag = s_q.released;
    assign serialShiftReg = s_q.shift;
    assign pinSample = s_q.sync2;
    assign shiftDoneIrq = s_q.irq;

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    count_bound_a: assert property (@(posedge clk) disable iff (!arst_n) s_q.count <= BIT_COUNT_END) // see R16
        else $error("counter passed eight");
    force_wait_a: assert property (@(posedge clk) disable iff (!arst_n) // see R17
        (transferStartWrite && !transferStartValue && !clockStop) |=> !s_q.released && s_q.count == BIT_COUNT_ZERO)
        else $error("forced wait missed");
    wdt_input_a: assert property (@(posedge clk) disable iff (!arst_n) // see R13
        watchdogStackReset |=> !portBitZeroOe && !portBitOneOe && !portBitTwoOe)
        else $error("pins not input after watchdog reset");
    irq_end_a: assert property (@(posedge clk) disable iff (!arst_n) // see R18
        shiftDoneIrq |-> !transferStartFlag || $past(transferStartWrite))
        else $error("irq without return to wait");
    stop_hold_a: assert property (@(posedge clk) disable iff (!arst_n) // see R14
        (clockStop && !watchdogStackReset) |=> $stable(serialShiftReg) && $stable(portBitTwoOut))
        else $error("state moved in clock stop");
    shared_serial_a: assert property (@(posedge clk) disable iff (!arst_n) // see R9
        (twoWireMode && dataIoSelect && !clockStop && !watchdogStackReset) |=> portBitOneOe)
        else $error("shared pin not driving");
    clock_dir_a: assert property (@(posedge clk) disable iff (!arst_n) // see R3
        (!clockPinDirection && !clockStop) |=> !portBitZeroOe)
        else $error("clock pin driven with direction zero");
    wait_high_a: assert property (@(posedge clk) disable iff (!arst_n) // see R4
        (!transferStartFlag && clockPinDirection && (clockSelectHigh || clockSelectLow)
        && !clockStop && !transferStartWrite) |=> portBitZeroOut)
        else $error("master clock not high in wait");

    // ---------------------------------------------------------------
    // checks on pin modes and shifting
    // ---------------------------------------------------------------
    // pin reset is left to the bench: the state is unknown until the first reset edge

    slave_clock_a: assert property (@(posedge clk) disable iff (!arst_n) // see R1
        (!clockSelectHigh && !clockSelectLow && transferStartFlag && !transferStartWrite)
        |=> $stable(s_q.intSck))
        else $error("internal clock moved in slave operation");

    start_flag_a: assert property (@(posedge clk) disable iff (!arst_n) // see R2
        (transferStartWrite && transferStartValue && !clockStop && !watchdogStackReset)
        |=> transferStartFlag)
        else $error("start write did not release the wait");

    slave_pin_a: assert property (@(posedge clk) disable iff (!arst_n) // see R3
        (!master && clockPinDirection && !clockStop && !watchdogStackReset)
        |=> portBitZeroOe && portBitZeroOut == $past(portLatch[0]))
        else $error("slave clock pin not a general output");

    master_pin_a: assert property (@(posedge clk) disable iff (!arst_n) // see R4
        (master && clockPinDirection && !clockStop && !watchdogStackReset)
        |=> portBitZeroOe && portBitZeroOut == s_q.intSck)
        else $error("master clock pin not showing internal clock");

    shared_dir_a: assert property (@(posedge clk) disable iff (!arst_n) // see R5
        (!(twoWireMode && dataIoSelect) && !clockStop && !watchdogStackReset)
        |=> portBitOneOe == $past(sharedPinDirection) && portBitOneOut == $past(portLatch[1]))
        else $error("shared pin not following its direction");

    out_drive_a: assert property (@(posedge clk) disable iff (!arst_n) // see R6
        (outputDriveEnable && !clockStop && !watchdogStackReset)
        |=> portBitTwoOe && portBitTwoOut == s_q.serOut)
        else $error("dedicated pin not giving serial output");

    // serial output changes only on falls or on a load, so a peer may sample on rises
    shift_msb_a: assert property (@(posedge clk) disable iff (!arst_n) // see R6 R11
        (transferStartFlag && fallEdge && s_q.count != BIT_COUNT_END && !shiftLoad && !clockStop)
        |=> s_q.serOut == $past(s_q.shift[DATA_W-1]))
        else $error("msb not shifted out on fall");

    // an output-mode pin hands in its latch instead of its level
    capture_lsb_a: assert property (@(posedge clk) disable iff (!arst_n) // see R7
        (transferStartFlag && riseEdge && (!twoWireMode || !transferDirectionSelect) && !shiftLoad && !clockStop)
        |=> s_q.shift[0] == $past(sdiIn))
        else $error("lsb not captured on rise");

    // the count runs on the pin, whoever clocks it
    count_step_a: assert property (@(posedge clk) disable iff (!arst_n) // see R8
        (transferStartFlag && fallEdge && s_q.count != BIT_COUNT_END && !clockStop
        && !transferStartWrite && !watchdogStackReset)
        |=> s_q.count == $past(s_q.count) + 1'b1)
        else $error("counter missed a falling edge");

    two_wire_out_a: assert property (@(posedge clk) disable iff (!arst_n) // see R9 R11
        (twoWireMode && dataIoSelect && !clockStop && !watchdogStackReset)
        |=> portBitOneOut == s_q.serOut)
        else $error("shared pin not giving serial output");

    port_follow_a: assert property (@(posedge clk) disable iff (!arst_n) // see R10
        (!outputDriveEnable && !clockStop && !watchdogStackReset)
        |=> portBitTwoOe == $past(outputPinDirection) && portBitTwoOut == $past(portLatch[2]))
        else $error("dedicated pin not a general port");

    // halt only stops the divider; a clock from outside keeps shifting
    halt_freeze_a: assert property (@(posedge clk) disable iff (!arst_n) // see R15
        (master && transferStartFlag && halt && !transferStartWrite)
        |=> $stable(s_q.intSck) && $stable(s_q.div))
        else $error("internal clock moved in halt");

    end_wait_a: assert property (@(posedge clk) disable iff (!arst_n) // see R16
        (transferStartFlag && riseEdge && s_q.count == BIT_COUNT_END && !clockStop && !transferStartWrite)
        |=> !transferStartFlag && shiftDoneIrq)
        else $error("eighth rise did not return to wait");

    irq_pulse_a: assert property (@(posedge clk) disable iff (!arst_n) // see R18
        shiftDoneIrq |=> !shiftDoneIrq)
        else $error("interrupt longer than one cycle");
endmodule // clocked_serial_port_pin_control

/* dv/serial_peer_model.sv */
// far-side serial peer: drives or follows the shift clock and swaps one byte
`timescale 1ns/1ps
module serial_peer_model (
    input wire logic sckWire,
    input wire logic dataFromDut,
    output logic sckOut,
    output logic dataToDut,
    output logic [7:0] rxByte
);
    logic [7:0] txByte = 8'h00;
    int bitIdx = 0;
    initial begin
        sckOut = 1'h1;
        dataToDut = 1'h0;
        rxByte = 8'h00;
    end
    task automatic prep(input logic [7:0] b);
        txByte = b;
        bitIdx = 0;
    endtask
    // clock runs only inside a frame, idles high
    task automatic frame();
        repeat (8) begin
            #24 sckOut = 1'h0;
            #24 sckOut = 1'h1;
        end
    endtask
    always @(negedge sckWire) if (bitIdx < 8) dataToDut <= txByte[3'(7 - bitIdx)];
    // sample on the rise: the device settles its output well after the fall
    always @(posedge sckWire) begin
        bitIdx <= bitIdx + 1;
        if (bitIdx == 7) dataToDut <= #24 ~dataToDut;
        rxByte <= {rxByte[6:0], dataFromDut};
    end
endmodule // serial_peer_model

/* dv/tb_top.sv */
// self-checking bench for the serial port pin control
`timescale 1ns/1ps
module tb_top;
    import csio_pkg::*;
    logic clk = 1'h0, arst_n = 1'h0, wd = 1'h0, stop = 1'h0, halt = 1'h0, selLo = 1'h0, two = 1'h0;
    logic tsW = 1'h0, tsV = 1'h0, ioSel = 1'h0, drv = 1'h1, dSel = 1'h0, d0 = 1'h0, d1 = 1'h0, d2 = 1'h0;
    logic load = 1'h0, o0, e0, o1, e1, o2, e2, flag, irq, sck, mosi;
    logic [2:0] latch = 3'h0, smp;
    logic [7:0] ld = 8'h00, sr, rx, last;
    logic [15:0] expQ[$], e;
    int miscompares = 0, cmp_count = 0, seed = 4;
    wire w0 = e0 ? o0 : sck;
    wire w1 = e1 ? o1 : mosi;
    wire w2 = e2 ? o2 : ~o2;
    always #2.5 clk = ~clk;
    clocked_serial_port_pin_control dut (.clk(clk), .arst_n(arst_n), .watchdogStackReset(wd), .clockStop(stop),
        .halt(halt), .clockSelectHigh(1'h0), .clockSelectLow(selLo), .twoWireMode(two), .transferStartWrite(tsW),
        .transferStartValue(tsV), .dataIoSelect(ioSel), .outputDriveEnable(drv), .transferDirectionSelect(dSel),
        .clockPinDirection(d0), .sharedPinDirection(d1), .outputPinDirection(d2), .portLatch(latch),
        .shiftLoad(load), .shiftLoadData(ld), .portBitZeroIn(w0), .portBitOneIn(w1), .portBitTwoIn(w2),
        .portBitZeroOut(o0), .portBitZeroOe(e0), .portBitOneOut(o1), .portBitOneOe(e1), .portBitTwoOut(o2),
        .portBitTwoOe(e2), .transferStartFlag(flag), .serialShiftReg(sr), .pinSample(smp), .shiftDoneIrq(irq));
    serial_peer_model peer (.sckWire(w0), .dataFromDut(w2), .sckOut(sck), .dataToDut(mosi), .rxByte(rx));
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic report_and_stop();
        if (miscompares == 0 && cmp_count > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task automatic start(input logic v);
        tsV = v;
        tsW = 1'h1;
        cyc(1);
        tsW = 1'h0;
        cyc(1);
    endtask
    // -----
    // one byte each way; slave frames are clocked by the peer
    // -----
    task automatic xfer(input logic slave);
        logic [7:0] tx;
        tx = 8'($random(seed));
        ld = 8'($random(seed));
        last = d1 ? {8{latch[1]}} : tx;
        peer.prep(tx);
        expQ.push_back({last, ld});
        load = 1'h1;
        cyc(1);
        load = 1'h0;
        start(1'h1);
        check("flag", {7'h0, flag}, 8'h01);
        check("oe", {5'h0, e2, e1, e0}, {5'h0, 1'h1, d1, ~slave});
        if (slave) peer.frame();
        for (int n = 0; n < 3000 && irq !== 1'h1; n++) cyc(1);
        cyc(2);
        check("flag end", {7'h0, flag}, 8'h00);
    endtask
    always @(negedge clk) if (irq === 1'h1) begin
        e = expQ.pop_front();
        check("shift in", sr, e[15:8]);
        check("shift out", rx, e[7:0]);
    end
    initial begin
        #100000;
        miscompares++;
        report_and_stop();
    end
    initial begin
        cyc(10);
        arst_n = 1'h1;
        check("oe reset", {5'h0, e2, e1, e0}, 8'h00);
        cyc(1);
        xfer(1'h1);
        selLo = 1'h1;
        d0 = 1'h1;
        xfer(1'h0);
        selLo = 1'h0;
        d0 = 1'h0;
        d1 = 1'h1;
        halt = 1'h1;
        latch = 3'($random(seed));
        xfer(1'h1);
        wd = 1'h1;
        cyc(1);
        check("oe wd", {5'h0, e2, e1, e0}, 8'h00);
        wd = 1'h0;
        cyc(2);
        check("shift wd", sr, last);
        stop = 1'h1;
        cyc(2);
        check("shift stop", sr, last);
        stop = 1'h0;
        {two, ioSel, dSel, drv, d1, halt} = 6'h38;
        start(1'h1);
        check("oe two", {6'h0, e2, e1}, {6'h0, d2, 1'h1});
        start(1'h0);
        check("forced", {7'h0, flag}, 8'h00);
        {selLo, d0, halt} = 3'h7;
        start(1'h1);
        cyc(20);
        check("halt clock", {7'h0, o0}, 8'h01);
        start(1'h0);
        report_and_stop();
    end
endmodule // tb_top
